// ---- core/beac_ctrl.sv ----
// Byte store access controller top: registers, cycle sequencer, done interrupt
`timescale 1ns/100ps
module beac_ctrl (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Slow sub-clock pin
  input wire logic sub_clk,
  // Core special register access
  input wire logic [7:0] core_addr,
  input wire logic core_wr,
  input wire logic core_rd,
  input wire logic [7:0] core_wdata,
  output logic [7:0] core_rdata,
  // Interrupt hand-off
  input wire logic core_stack_full,
  output logic irq_vector
);
  logic rst_meta_ff, rst_sync_ff;
  logic [7:0] ptr1_low_ff, nxt_ptr1_low, ptr1_high_ff, nxt_ptr1_high;
  logic [4:0] cell_index_ff, nxt_cell_index, cap_idx_ff, nxt_cap_idx;
  logic [7:0] cell_byte_ff, nxt_cell_byte, cap_byte_ff, nxt_cap_byte;
  logic ctl_b7_ff, nxt_ctl_b7;
  logic program_unlock_ff, nxt_program_unlock, write_go_ff, nxt_write_go;
  logic fetch_unlock_ff, nxt_fetch_unlock, read_go_ff, nxt_read_go;
  logic global_irq_enable_ff, nxt_global_irq_enable;
  logic done_irq_mask_ff, nxt_done_irq_mask;
  logic done_irq_flag_ff, nxt_done_irq_flag;
  logic [7:0] core_rdata_ff, nxt_core_rdata;
  logic irq_vector_ff, nxt_irq_vector;
  beac_pkg::beac_state_t state_ff, nxt_state;
  logic [2:0] rd_cnt_ff, nxt_rd_cnt;
  logic indirect, sel0, sel_ctrl;
  logic [7:0] eff_sec, eff_ofs, rd_val, ctl_val, irq_val;
  logic wr_accept, rd_accept, cell_we, timer_done;
  logic [7:0] arr_rdata;

  // Reset release through two flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // R1 store held as flops
  beac_cell_array u_array (
    .mclk(mclk),
    .we(cell_we),
    .widx(cap_idx_ff),
    .wdata(cap_byte_ff),
    .ridx(cap_idx_ff),
    .rdata(arr_rdata)
  );

  // Write length follows the sub-clock; with it stopped a write never ends
  // R13 sub-clock timed write
  beac_sub_timer u_timer (
    .mclk(mclk),
    .rst_n(rst_sync_ff),
    .sub_clk(sub_clk),
    .start(wr_accept),
    .done(timer_done)
  );

  // R2 indirect address resolve
  always_comb begin
    indirect = (core_addr == beac_pkg::OFS_INDIRECT1);
    eff_sec = indirect ? ptr1_high_ff : beac_pkg::SECTOR0;
    eff_ofs = indirect ? ptr1_low_ff : core_addr;
    sel0 = (eff_sec == beac_pkg::SECTOR0);
    sel_ctrl = (eff_sec == beac_pkg::CTRL_SECTOR) && (eff_ofs == beac_pkg::CTRL_OFS);
  end

  // R4 control readback layout
  always_comb begin
    ctl_val = 8'h00;
    ctl_val[beac_pkg::CTL_RESERVED] = ctl_b7_ff;
    ctl_val[beac_pkg::CTL_PROG_UNLOCK] = program_unlock_ff;
    ctl_val[beac_pkg::CTL_PROG_GO] = write_go_ff;
    ctl_val[beac_pkg::CTL_FETCH_UNLOCK] = fetch_unlock_ff;
    ctl_val[beac_pkg::CTL_FETCH_GO] = read_go_ff;
    irq_val = 8'h00;
    irq_val[beac_pkg::IRQ_GLOBAL] = global_irq_enable_ff;
    irq_val[beac_pkg::IRQ_MASK] = done_irq_mask_ff;
    irq_val[beac_pkg::IRQ_FLAG] = done_irq_flag_ff;
    rd_val = 8'h00;
    if (sel_ctrl) begin
      rd_val = ctl_val;
    end else if (sel0) begin
      unique case (eff_ofs)
        beac_pkg::OFS_PTR1_LOW: rd_val = ptr1_low_ff;
        beac_pkg::OFS_PTR1_HIGH: rd_val = ptr1_high_ff;
        beac_pkg::OFS_IRQ_CTRL: rd_val = irq_val;
        // R3 upper index bits zero
        beac_pkg::OFS_CELL_INDEX: rd_val = {3'h0, cell_index_ff};
        beac_pkg::OFS_CELL_BYTE: rd_val = cell_byte_ff;
        default: rd_val = 8'h00;
      endcase
    end
  end

  always_comb begin
    nxt_ptr1_low = ptr1_low_ff;
    nxt_ptr1_high = ptr1_high_ff;
    nxt_cell_index = cell_index_ff;
    // R10 byte held by default
    nxt_cell_byte = cell_byte_ff;
    nxt_cap_idx = cap_idx_ff;
    nxt_cap_byte = cap_byte_ff;
    nxt_ctl_b7 = ctl_b7_ff;
    nxt_program_unlock = program_unlock_ff;
    nxt_write_go = write_go_ff;
    nxt_fetch_unlock = fetch_unlock_ff;
    nxt_read_go = read_go_ff;
    nxt_global_irq_enable = global_irq_enable_ff;
    nxt_done_irq_mask = done_irq_mask_ff;
    nxt_done_irq_flag = done_irq_flag_ff;
    nxt_state = state_ff;
    nxt_rd_cnt = rd_cnt_ff;
    nxt_irq_vector = 1'b0;
    nxt_core_rdata = core_rd ? rd_val : core_rdata_ff;
    wr_accept = 1'b0;
    rd_accept = 1'b0;
    cell_we = 1'b0;
    if (core_wr && sel0) begin
      unique case (eff_ofs)
        beac_pkg::OFS_PTR1_LOW: nxt_ptr1_low = core_wdata;
        beac_pkg::OFS_PTR1_HIGH: nxt_ptr1_high = core_wdata;
        beac_pkg::OFS_CELL_INDEX: nxt_cell_index = core_wdata[4:0];
        beac_pkg::OFS_CELL_BYTE: nxt_cell_byte = core_wdata;
        beac_pkg::OFS_IRQ_CTRL: begin
          nxt_global_irq_enable = core_wdata[beac_pkg::IRQ_GLOBAL];
          nxt_done_irq_mask = core_wdata[beac_pkg::IRQ_MASK];
          nxt_done_irq_flag = core_wdata[beac_pkg::IRQ_FLAG];
        end
        default: nxt_ptr1_low = ptr1_low_ff;
      endcase
    end
    if (core_wr && sel_ctrl) begin
      nxt_ctl_b7 = core_wdata[beac_pkg::CTL_RESERVED];
      nxt_program_unlock = core_wdata[beac_pkg::CTL_PROG_UNLOCK];
      nxt_fetch_unlock = core_wdata[beac_pkg::CTL_FETCH_UNLOCK];
      if (state_ff == beac_pkg::ST_IDLE) begin
        // R5 go needs earlier unlock
        wr_accept = core_wdata[beac_pkg::CTL_PROG_GO] && program_unlock_ff;
        // R6 go needs earlier unlock
        rd_accept = core_wdata[beac_pkg::CTL_FETCH_GO] && fetch_unlock_ff && !wr_accept;
      end
    end
    // R18 vector gating
    if (global_irq_enable_ff && done_irq_mask_ff && done_irq_flag_ff && !core_stack_full) begin
      nxt_irq_vector = 1'b1;
      // R19 service clears
      nxt_done_irq_flag = 1'b0;
      nxt_global_irq_enable = 1'b0;
    end
    unique case (state_ff)
      beac_pkg::ST_IDLE: begin
        // R22 capture at start
        if (wr_accept) begin
          nxt_state = beac_pkg::ST_WRITE;
          nxt_write_go = 1'b1;
          nxt_cap_idx = cell_index_ff;
          nxt_cap_byte = cell_byte_ff;
        end else if (rd_accept) begin
          nxt_state = beac_pkg::ST_READ;
          nxt_read_go = 1'b1;
          nxt_rd_cnt = beac_pkg::READ_CYCLES - 3'h1;
          nxt_cap_idx = cell_index_ff;
        end
      end
      beac_pkg::ST_READ: begin
        if (rd_cnt_ff == 3'h0) begin
          nxt_state = beac_pkg::ST_IDLE;
          // R9 clear go, present byte
          nxt_read_go = 1'b0;
          // R7 read blocked when locked
          if (fetch_unlock_ff) begin
            nxt_cell_byte = arr_rdata;
          end
        end else begin
          nxt_rd_cnt = rd_cnt_ff - 3'h1;
        end
      end
      beac_pkg::ST_WRITE: begin
        if (timer_done) begin
          nxt_state = beac_pkg::ST_IDLE;
          // R8 clear go at end
          nxt_write_go = 1'b0;
          // R17 set wins over clear
          nxt_done_irq_flag = 1'b1;
          // Unlock looked at again at commit, so a late clear still spares the cells
          // R7 write blocked when locked
          cell_we = program_unlock_ff;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      ptr1_low_ff <= beac_pkg::RST_BYTE;
      // R16 reset selects sector 0
      ptr1_high_ff <= beac_pkg::RST_BYTE;
      cell_index_ff <= beac_pkg::RST_INDEX;
      cell_byte_ff <= beac_pkg::RST_BYTE;
      cap_idx_ff <= beac_pkg::RST_INDEX;
      cap_byte_ff <= beac_pkg::RST_BYTE;
      ctl_b7_ff <= 1'b0;
      // R16 reset locks writes
      program_unlock_ff <= 1'b0;
      write_go_ff <= 1'b0;
      fetch_unlock_ff <= 1'b0;
      read_go_ff <= 1'b0;
      global_irq_enable_ff <= 1'b0;
      done_irq_mask_ff <= 1'b0;
      done_irq_flag_ff <= 1'b0;
      state_ff <= beac_pkg::ST_IDLE;
      rd_cnt_ff <= 3'h0;
      core_rdata_ff <= beac_pkg::RST_BYTE;
      irq_vector_ff <= 1'b0;
    end else begin
      ptr1_low_ff <= nxt_ptr1_low;
      ptr1_high_ff <= nxt_ptr1_high;
      cell_index_ff <= nxt_cell_index;
      cell_byte_ff <= nxt_cell_byte;
      cap_idx_ff <= nxt_cap_idx;
      cap_byte_ff <= nxt_cap_byte;
      ctl_b7_ff <= nxt_ctl_b7;
      program_unlock_ff <= nxt_program_unlock;
      write_go_ff <= nxt_write_go;
      fetch_unlock_ff <= nxt_fetch_unlock;
      read_go_ff <= nxt_read_go;
      global_irq_enable_ff <= nxt_global_irq_enable;
      done_irq_mask_ff <= nxt_done_irq_mask;
      done_irq_flag_ff <= nxt_done_irq_flag;
      state_ff <= nxt_state;
      rd_cnt_ff <= nxt_rd_cnt;
      core_rdata_ff <= nxt_core_rdata;
      irq_vector_ff <= nxt_irq_vector;
    end
  end

  assign core_rdata = core_rdata_ff;
  assign irq_vector = irq_vector_ff;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_sync_ff);

  a_index_upper_zero: // R3
    assert property (core_rd && sel0 && eff_ofs == beac_pkg::OFS_CELL_INDEX
      |=> core_rdata[7:5] == 3'h0) else $error("index upper bits not zero");
  a_ctrl_unused_zero: // R4
    assert property (core_rd && sel_ctrl |=> core_rdata[6:4] == 3'h0)
      else $error("control bits 6..4 not zero");
  a_ctrl_direct_hidden: // R2
    assert property (core_rd && core_addr == beac_pkg::CTRL_OFS |=> core_rdata == 8'h00)
      else $error("control register reached directly");
  a_wgo_gated: // R5
    assert property (state_ff == beac_pkg::ST_IDLE && core_wr && sel_ctrl
      && !program_unlock_ff |=> !write_go_ff && state_ff != beac_pkg::ST_WRITE)
      else $error("write started without prior unlock");
  a_rgo_gated: // R6
    assert property (state_ff == beac_pkg::ST_IDLE && core_wr && sel_ctrl
      && !fetch_unlock_ff |=> !read_go_ff) else $error("read started without prior unlock");
  a_no_locked_write: // R7
    assert property (cell_we |-> program_unlock_ff) else $error("store written while locked");
  a_wgo_self_clear: // R8
    assert property (state_ff == beac_pkg::ST_WRITE && timer_done
      |=> !write_go_ff && done_irq_flag_ff) else $error("write end not signalled");
  a_read_result: // R9
    assert property ($fell(read_go_ff) && $past(fetch_unlock_ff)
      |-> cell_byte_ff == $past(arr_rdata)) else $error("fetched byte not presented");
  a_read_length: // R9
    assert property ($rose(read_go_ff) |-> read_go_ff [*4] ##1 !read_go_ff)
      else $error("read cycle length wrong");
  a_vector_gate: // R18
    assert property (irq_vector_ff |-> $past(global_irq_enable_ff) && $past(done_irq_mask_ff)
      && $past(done_irq_flag_ff) && !$past(core_stack_full))
      else $error("vector without enables");
  a_service_clear: // R19
    assert property (irq_vector_ff |-> !global_irq_enable_ff)
      else $error("global enable not cleared on service");
  a_capture_stable: // R22
    assert property (state_ff != beac_pkg::ST_IDLE && $past(state_ff) != beac_pkg::ST_IDLE
      |-> $stable(cap_idx_ff) && $stable(cap_byte_ff)) else $error("captured operands moved");
  a_byte_held: // R10
    assert property (!(core_wr && sel0 && eff_ofs == beac_pkg::OFS_CELL_BYTE)
      && !(state_ff == beac_pkg::ST_READ && rd_cnt_ff == 3'h0) |=> $stable(cell_byte_ff))
      else $error("byte register moved without an operation");
  a_wgo_while_busy: // R8
    assert property (state_ff == beac_pkg::ST_WRITE |-> write_go_ff)
      else $error("write go dropped before the write ended");
  a_flag_source: // R17
    assert property (!done_irq_flag_ff && !(state_ff == beac_pkg::ST_WRITE && timer_done)
      && !(core_wr && sel0 && eff_ofs == beac_pkg::OFS_IRQ_CTRL) |=> !done_irq_flag_ff)
      else $error("done flag set without a write end");
  a_vector_pulse: // R19
    assert property (irq_vector_ff |=> !irq_vector_ff)
      else $error("vector longer than one cycle");

  c_write_done: cover property (state_ff == beac_pkg::ST_WRITE && timer_done && cell_we);
  c_read_done: cover property ($fell(read_go_ff) && fetch_unlock_ff);
  c_vector: cover property (irq_vector_ff);
  c_refused_go: cover property (core_wr && sel_ctrl && core_wdata[2] && !program_unlock_ff);
  c_locked_fetch: cover property (state_ff == beac_pkg::ST_READ && rd_cnt_ff == 3'h0
    && !fetch_unlock_ff);
endmodule

// ---- common/beac_pkg.sv ----
// Constants and types for the byte store access controller
// Summary of operation
// R1 - Thirty-two byte store, reached one byte at a time through three registers.
// R2 - Control register at 40H of sector 1, reached only through indirect pointer.
// R3 - Index register holds five bits; bits 7 to 5 read zero.
// R4 - Control bits: program unlock 3, program go 2, fetch unlock 1, fetch go 0.
// R5 - Program go is ignored unless program unlock was already set.
// R6 - Fetch go is ignored unless fetch unlock was already set.
// R7 - Clear unlock bits block any store write or read.
// R8 - Hardware clears program go when the write cycle ends.
// R9 - Hardware clears fetch go when read ends; byte register holds fetched byte.
// R10 - Fetched byte stays in byte register until the next operation.
// R11 - Software loads index and byte, then unlock and go back to back.
// R12 - Software never sets unlock with go, nor read and write together.
// R13 - Write cycle is timed by a timer on the slow sub-clock.
// R14 - Software keeps sub-clock stable and registers untouched during writes.
// R15 - Software masks global interrupts around the start of a write.
// R16 - Reset clears program unlock and pointer high byte.
// R17 - Write end sets done flag; only its mask lets it interrupt.
// R18 - Vector only with global enable, mask, flag and stack not full.
// R19 - Servicing the vector clears the flag and global enable.
// R20 - Software reloads the index and sets fetch go for every read.
// R21 - Software avoids idle or sleep while a cycle is running.
// R22 - Index and byte captured at cycle start stay stable until it ends.
package beac_pkg;
  localparam int DATA_W = 8;
  localparam int INDEX_W = 5;
  localparam int DEPTH = 32;
  localparam logic [7:0] SECTOR0 = 8'h00;
  localparam logic [7:0] CTRL_SECTOR = 8'h01;
  localparam logic [7:0] CTRL_OFS = 8'h40;
  localparam logic [7:0] OFS_INDIRECT1 = 8'h00;
  localparam logic [7:0] OFS_PTR1_LOW = 8'h01;
  localparam logic [7:0] OFS_PTR1_HIGH = 8'h02;
  localparam logic [7:0] OFS_IRQ_CTRL = 8'h0E;
  localparam logic [7:0] OFS_CELL_INDEX = 8'h1E;
  localparam logic [7:0] OFS_CELL_BYTE = 8'h1F;
  localparam int CTL_RESERVED = 7;
  localparam int CTL_PROG_UNLOCK = 3;
  localparam int CTL_PROG_GO = 2;
  localparam int CTL_FETCH_UNLOCK = 1;
  localparam int CTL_FETCH_GO = 0;
  localparam int IRQ_GLOBAL = 0;
  localparam int IRQ_MASK = 1;
  localparam int IRQ_FLAG = 2;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [4:0] RST_INDEX = 5'h00;
  localparam logic [2:0] READ_CYCLES = 3'h4;
  localparam logic [3:0] WRITE_TICKS = 4'h8;
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} beac_state_t;
endpackage

// ---- core/beac_cell_array.sv ----
// Thirty-two byte flip-flop store
`timescale 1ns/100ps
module beac_cell_array (
  // Clock
  input wire logic mclk,
  // Write port
  input wire logic we,
  input wire logic [4:0] widx,
  input wire logic [7:0] wdata,
  // Read port
  input wire logic [4:0] ridx,
  output logic [7:0] rdata
);
  // Contents survive reset, standing in for the non-volatile cells
  logic [7:0] mem_ff [beac_pkg::DEPTH];

  always_ff @(posedge mclk) begin
    if (we) begin
      mem_ff[widx] <= wdata;
    end
  end

  assign rdata = mem_ff[ridx];
endmodule

// ---- core/beac_sub_timer.sv ----
// Write timer counting edges of the slow sub-clock
`timescale 1ns/100ps
module beac_sub_timer (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Sub-clock pin
  input wire logic sub_clk,
  // Control
  input wire logic start,
  output logic done
);
  logic meta_ff, sync_ff, prev_ff, run_ff, done_ff;
  logic nxt_prev, nxt_run, nxt_done;
  logic [3:0] cnt_ff, nxt_cnt;
  logic tick;

  always_comb begin
    tick = sync_ff && !prev_ff;
    nxt_prev = sync_ff;
    nxt_run = run_ff;
    nxt_cnt = cnt_ff;
    nxt_done = 1'b0;
    if (start) begin
      nxt_run = 1'b1;
      nxt_cnt = beac_pkg::WRITE_TICKS;
    end else if (run_ff && tick) begin
      if (cnt_ff == 4'h1) begin
        nxt_run = 1'b0;
        nxt_done = 1'b1;
      end
      nxt_cnt = cnt_ff - 4'h1;
    end
  end

  // Pin is foreign to mclk, so two flops before the edge detector
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
      run_ff <= 1'b0;
      cnt_ff <= 4'h0;
      done_ff <= 1'b0;
    end else begin
      meta_ff <= sub_clk;
      sync_ff <= meta_ff;
      prev_ff <= nxt_prev;
      run_ff <= nxt_run;
      cnt_ff <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  assign done = done_ff;
endmodule

// ---- tb/beac_core_model.sv ----
// Core model driving the special register bus like firmware
`timescale 1ns/100ps
module beac_core_model (
  // Clock
  input wire logic mclk,
  // Register bus
  output logic [7:0] core_addr,
  output logic core_wr,
  output logic core_rd,
  output logic [7:0] core_wdata,
  input wire logic [7:0] core_rdata
);
  initial begin
    core_addr = 8'h00;
    core_wr = 1'b0;
    core_rd = 1'b0;
    core_wdata = 8'h00;
  end

  // Released lines show the inverse, not a stale copy
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    core_addr <= a;
    core_wdata <= d;
    core_wr <= 1'b1;
    @(posedge mclk);
    core_wr <= 1'b0;
    core_addr <= ~a;
    core_wdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    core_addr <= a;
    core_rd <= 1'b1;
    @(posedge mclk);
    core_rd <= 1'b0;
    core_addr <= ~a;
    #1 d = core_rdata;
  endtask

  task automatic ptr();
    wr(beac_pkg::OFS_PTR1_LOW, beac_pkg::CTRL_OFS);
    wr(beac_pkg::OFS_PTR1_HIGH, beac_pkg::CTRL_SECTOR);
  endtask

  task automatic prog(input logic [4:0] i, input logic [7:0] d);
    wr(beac_pkg::OFS_CELL_INDEX, {3'h0, i});
    wr(beac_pkg::OFS_CELL_BYTE, d);
    ptr();
    wr(beac_pkg::OFS_INDIRECT1, 8'h08);
    wr(beac_pkg::OFS_INDIRECT1, 8'h0C);
  endtask

  task automatic fetch(input logic [4:0] i);
    wr(beac_pkg::OFS_CELL_INDEX, {3'h0, i});
    ptr();
    wr(beac_pkg::OFS_INDIRECT1, 8'h02);
    wr(beac_pkg::OFS_INDIRECT1, 8'h03);
  endtask
endmodule

// ---- tb/beac_ctrl_tb_top.sv ----
// Self-checking bench for the byte store access controller
`timescale 1ns/100ps
module beac_ctrl_tb_top;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic sub_clk = 1'b0;
  logic core_stack_full = 1'b0;
  logic [7:0] core_addr;
  logic [7:0] core_wdata;
  logic [7:0] core_rdata;
  logic core_wr;
  logic core_rd;
  logic irq_vector;
  logic [7:0] v;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  int vec_count = 0;

  always #25 mclk = ~mclk;

  // Sub-clock from the system clock keeps inputs off the sampling edge
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc % 5 == 4) begin
      sub_clk <= ~sub_clk;
    end
    if (irq_vector === 1'b1) begin
      vec_count++;
    end
    if (cyc == 60000) begin
      err_count++;
      summarize();
    end
  end

  beac_ctrl i_dut (
    .mclk(mclk),
    .rst_n(rst_n),
    .sub_clk(sub_clk),
    .core_addr(core_addr),
    .core_wr(core_wr),
    .core_rd(core_rd),
    .core_wdata(core_wdata),
    .core_rdata(core_rdata),
    .core_stack_full(core_stack_full),
    .irq_vector(irq_vector)
  );

  beac_core_model i_core (
    .mclk(mclk),
    .core_addr(core_addr),
    .core_wr(core_wr),
    .core_rd(core_rd),
    .core_wdata(core_wdata),
    .core_rdata(core_rdata)
  );

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  // only polling while a cycle runs
  task automatic poll(input int b);
    int n;
    n = 0;
    i_core.rd(8'h00, v);
    while (v[b] !== 1'b0 && n < 300) begin
      i_core.rd(8'h00, v);
      n++;
    end
    chk("go bit", 8'h00, {7'h00, v[b]});
  endtask

  task automatic t_reset();
    i_core.rd(beac_pkg::OFS_PTR1_HIGH, v);
    chk("pointer high", 8'h00, v);
    i_core.rd(beac_pkg::OFS_CELL_BYTE, v);
    chk("byte", 8'h00, v);
    i_core.rd(beac_pkg::CTRL_OFS, v);
    chk("direct 40", 8'h00, v);
    i_core.wr(8'h00, 8'h08);
    i_core.ptr();
    i_core.rd(8'h00, v);
    chk("control", 8'h00, v);
  endtask

  task automatic t_fields();
    i_core.wr(beac_pkg::OFS_CELL_INDEX, 8'hFF);
    i_core.rd(beac_pkg::OFS_CELL_INDEX, v);
    chk("index", 8'h1F, v);
    i_core.wr(8'h00, 8'hF0);
    i_core.rd(8'h00, v);
    chk("control", 8'h80, v);
    i_core.rd(beac_pkg::CTRL_OFS, v);
    chk("direct 40 set", 8'h00, v);
    i_core.wr(beac_pkg::CTRL_OFS, 8'h08);
    i_core.rd(8'h00, v);
    chk("direct write", 8'h80, v);
    i_core.wr(8'h00, 8'h00);
  endtask

  task automatic t_rw();
    logic [4:0] ix[2];
    logic [7:0] dt[2];
    ix = '{5'h00, 5'h1F};
    dt = '{8'hA5, 8'h3C};
    for (int k = 0; k < 2; k++) begin
      i_core.prog(ix[k], dt[k]);
      poll(beac_pkg::CTL_PROG_GO);
      i_core.rd(beac_pkg::OFS_IRQ_CTRL, v);
      chk("done flag", 8'h04, v);
      i_core.wr(beac_pkg::OFS_IRQ_CTRL, 8'h00);
    end
    for (int k = 0; k < 2; k++) begin
      i_core.fetch(ix[k]);
      poll(beac_pkg::CTL_FETCH_GO);
      i_core.rd(beac_pkg::OFS_CELL_BYTE, v);
      chk("fetched", dt[k], v);
      i_core.rd(beac_pkg::OFS_CELL_BYTE, v);
      chk("held", dt[k], v);
    end
    // A locked program go leaves the store alone
    i_core.wr(8'h00, 8'h00);
    i_core.wr(beac_pkg::OFS_CELL_INDEX, 8'h00);
    i_core.wr(beac_pkg::OFS_CELL_BYTE, 8'h77);
    i_core.wr(8'h00, 8'h04);
    repeat (200) @(posedge mclk);
    i_core.fetch(5'h00);
    poll(beac_pkg::CTL_FETCH_GO);
    i_core.rd(beac_pkg::OFS_CELL_BYTE, v);
    chk("locked store", 8'hA5, v);
    // Fetch unlock dropped while the read runs keeps the old byte
    i_core.wr(beac_pkg::OFS_CELL_BYTE, 8'h5A);
    i_core.fetch(5'h00);
    i_core.wr(8'h00, 8'h00);
    poll(beac_pkg::CTL_FETCH_GO);
    i_core.rd(beac_pkg::OFS_CELL_BYTE, v);
    chk("locked fetch", 8'h5A, v);
  endtask

  task automatic t_rerst();
    i_core.ptr();
    i_core.wr(8'h00, 8'h08);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    i_core.rd(beac_pkg::OFS_PTR1_HIGH, v);
    chk("pointer high again", 8'h00, v);
    i_core.ptr();
    i_core.rd(8'h00, v);
    chk("unlock after reset", 8'h00, v);
    i_core.fetch(5'h1F);
    poll(beac_pkg::CTL_FETCH_GO);
    i_core.rd(beac_pkg::OFS_CELL_BYTE, v);
    chk("kept over reset", 8'h3C, v);
  endtask

  task automatic t_locked();
    i_core.ptr();
    i_core.wr(8'h00, 8'h00);
    i_core.wr(8'h00, 8'h04);
    i_core.rd(8'h00, v);
    chk("write go", 8'h00, v);
    i_core.wr(8'h00, 8'h01);
    i_core.rd(8'h00, v);
    chk("read go", 8'h00, v);
    i_core.wr(8'h00, 8'h0C);
    i_core.rd(8'h00, v);
    chk("joint write", 8'h08, v);
    i_core.wr(8'h00, 8'h03);
    i_core.rd(8'h00, v);
    chk("joint read", 8'h02, v);
    i_core.wr(8'h00, 8'h00);
  endtask

  task automatic t_irq();
    @(posedge mclk);
    core_stack_full <= 1'b1;
    i_core.wr(beac_pkg::OFS_IRQ_CTRL, 8'h02);
    i_core.prog(5'h07, 8'hC3);
    // global enable only once the write runs
    i_core.wr(beac_pkg::OFS_IRQ_CTRL, 8'h03);
    poll(beac_pkg::CTL_PROG_GO);
    i_core.rd(beac_pkg::OFS_IRQ_CTRL, v);
    chk("pending", 8'h07, v);
    chk("no vector", 8'h00, 8'(vec_count));
    @(posedge mclk);
    core_stack_full <= 1'b0;
    repeat (3) @(posedge mclk);
    #1 chk("vector", 8'h01, 8'(vec_count));
    i_core.rd(beac_pkg::OFS_IRQ_CTRL, v);
    chk("serviced", 8'h02, v);
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    t_reset();
    t_fields();
    t_rw();
    t_locked();
    t_rerst();
    t_irq();
    summarize();
  end
endmodule
